// ===== logic/atd_pkg.sv
// Purpose: shared constants for the transmit descriptor engine
// Assumes: 32-bit APB, 32-bit host memory words, 16-byte descriptor units
// Notes: field positions follow the descriptor word layout used by software
package atd_pkg;
    // apb register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_CMDPTR = 8'h04;
    localparam logic [7:0] OFS_STATUS = 8'h08;
    localparam logic [7:0] OFS_PING = 8'h0C;
    // context_control_word bit positions
    localparam int CTRL_RUN_BIT = 15;
    localparam int CTRL_WAKE_BIT = 12;
    localparam int CTRL_ACTIVE_BIT = 10;
    localparam int CTRL_EVT_LSB = 0;
    localparam int EVT_W = 5;
    localparam logic [15:0] CTRL_RESET = 16'h0000;
    localparam logic [31:0] CMDPTR_RESET = 32'h0000_0000;
    // descriptor word0 fields
    localparam int CMD_LSB = 28;
    localparam int KEY_LSB = 24;
    localparam int PING_BIT = 23;
    localparam logic [3:0] CMD_OUT_LAST = 4'h1;
    localparam logic [2:0] KEY_IMMEDIATE = 3'h2;
    // word index inside a unit
    localparam logic [1:0] WRD_HDR = 2'h0;
    localparam logic [1:0] WRD_BRANCH = 2'h2;
    localparam logic [1:0] WRD_STATUS = 2'h3;
    localparam int WORDS_PER_UNIT = 4;
    localparam int UNIT_BYTES = 16;
    // block count encodings
    localparam logic [3:0] Z_END = 4'h0;
    localparam logic [3:0] Z_MIN = 4'h2;
    localparam logic [3:0] Z_MAX = 4'h8;
    localparam logic [3:0] IMM_UNITS = 4'h2;
    // time stamp layout
    localparam int SEC_W = 3;
    localparam int CYC_W = 13;
    localparam int STAMP_W = 16;
    localparam logic [EVT_W-1:0] EVT_TIMEOUT_CODE = 5'h0A;
    localparam logic [EVT_W-1:0] EVT_BAD_Z_CODE = 5'h05;
    typedef enum logic [3:0] {
        ST_IDLE, ST_FETCH, ST_CHECK, ST_SEND, ST_WAIT_LINK, ST_WAIT_ACK,
        ST_WB, ST_END, ST_POLL
    } atd_state_type;
endpackage

// ===== logic/atd_desc_mem.sv
// Purpose: holds one prefetched descriptor block
// Assumes: single clock, one write and one read port
// Notes: read data is registered, one cycle latency
`timescale 1ns/1ps
module atd_desc_mem #(
    parameter int DEPTH = 32,
    parameter int AW = 5
) (
    input wire logic clk_i,
    input wire logic we_i,
    input wire logic [AW-1:0] waddr_i,
    input wire logic [31:0] wdata_i,
    input wire logic [AW-1:0] raddr_i,
    output logic [31:0] rdata_o
);
    logic [31:0] mem_reg [DEPTH];

    always_ff @(posedge clk_i) begin
        if (we_i) begin
            mem_reg[waddr_i] <= wdata_i;
        end
        rdata_o <= mem_reg[raddr_i];
    end
endmodule

// ===== logic/atd_engine.sv
// Purpose: transmit descriptor fetch, completion writeback and ping timing
// Assumes: link events and ack results arrive on clk_i; ping time base is a pin
// Notes: ping_tick_i toggles once per ping clock; it must toggle slower than clk_i/2
//
// Chosen here: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
module atd_engine
    import atd_pkg::*;
#(
    parameter int MAX_UNITS = 8,
    parameter int MEM_AW = 5
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    output logic mem_req_o,
    output logic mem_we_o,
    output logic [31:0] mem_addr_o,
    output logic [31:0] mem_wdata_o,
    input wire logic mem_ack_i,
    input wire logic [31:0] mem_rdata_i,
    input wire logic [MEM_AW-1:0] tx_raddr_i,
    output logic [31:0] tx_rdata_o,
    output logic [MEM_AW-1:0] tx_base_o,
    output logic tx_start_o,
    input wire logic link_done_i,
    input wire logic ack_rcvd_i,
    input wire logic ack_busy_i,
    input wire logic [EVT_W-1:0] ack_code_i,
    input wire logic ack_timeout_i,
    input wire logic rx_indication_i,
    input wire logic subaction_gap_i,
    input wire logic [SEC_W-1:0] seconds_low_bits_i,
    input wire logic [CYC_W-1:0] cycle_number_i,
    input wire logic ping_tick_i,
    output logic active_o
);
    atd_state_type state_reg, state_next;
    logic [15:0] ctrl_reg;
    logic [EVT_W-1:0] evt_reg;
    logic [31:0] cmdptr_reg;
    logic [MEM_AW-1:0] widx_reg;
    logic [3:0] walk_unit_reg;
    logic [3:0] last_unit_reg;
    logic found_last_reg;
    logic ping_flag_reg;
    logic [31:0] branch_reg;
    logic [STAMP_W-1:0] stamp_reg;
    logic [STAMP_W-1:0] ping_cnt_reg;
    logic ping_run_reg;
    logic [STAMP_W-1:0] ping_last_reg;
    logic [2:0] tick_sync_reg;
    logic tx_start_reg;

    function automatic logic [31:0] unit_addr(input logic [31:0] base, input logic [3:0] unit,
                                             input logic [1:0] word);
        unit_addr = {base[31:4], 4'h0} + {24'h00_0000, unit, 4'h0} + {28'h000_0000, word, 2'b00};
    endfunction

    // apb decode
    wire apb_access = psel_i & penable_i;
    wire apb_wr = apb_access & pwrite_i;
    wire hit_ctrl = (paddr_i == OFS_CTRL);
    wire hit_cmdptr = (paddr_i == OFS_CMDPTR);
    wire hit_status = (paddr_i == OFS_STATUS);
    wire hit_ping = (paddr_i == OFS_PING);
    wire addr_ok = hit_ctrl | hit_cmdptr | hit_status | hit_ping;
    wire run = ctrl_reg[CTRL_RUN_BIT];
    wire wake_wr = apb_wr & hit_ctrl & pwdata_i[CTRL_WAKE_BIT];
    wire busy = (state_reg != ST_IDLE);
    wire [15:0] ctx_word = {ctrl_reg[15:11], busy, ctrl_reg[9:EVT_W], evt_reg};
    wire [3:0] cmd_z = cmdptr_reg[3:0];
    wire [3:0] branch_z = branch_reg[3:0];
    wire z_legal = (cmd_z >= Z_MIN) && (cmd_z <= Z_MAX);

    assign pready_o = 1'b1;
    assign pslverr_o = apb_access & ~addr_ok;
    assign prdata_o = hit_ctrl ? {16'h0000, ctx_word} :
                      hit_cmdptr ? cmdptr_reg :
                      hit_status ? {12'h000, state_reg, stamp_reg} :
                      hit_ping ? {16'h0000, ping_last_reg} : 32'h0000_0000;
    assign active_o = busy;
    assign tx_start_o = tx_start_reg;
    assign tx_base_o = MEM_AW'(0);

    // fetch walk over the incoming block
    wire fetch_beat = (state_reg == ST_FETCH) & mem_ack_i;
    wire [3:0] beat_unit = 4'(widx_reg[MEM_AW-1:2]);
    wire [1:0] beat_word = widx_reg[1:0];
    wire [3:0] fetch_units = cmd_z;
    wire fetch_last_beat = fetch_beat && (beat_unit == fetch_units - 4'h1) && (beat_word == 2'h3);
    wire hdr_beat = fetch_beat && (beat_word == WRD_HDR) && (beat_unit == walk_unit_reg);
    wire hdr_is_last = mem_rdata_i[CMD_LSB +: 4] == CMD_OUT_LAST;
    wire hdr_is_imm = mem_rdata_i[KEY_LSB +: 3] == KEY_IMMEDIATE;
    wire br_beat = fetch_beat && (beat_word == WRD_BRANCH) && found_last_reg &&
                   (beat_unit == last_unit_reg);

    // completion writeback word: status high half, stamp low half
    wire [15:0] stamp_now = {seconds_low_bits_i, cycle_number_i};
    wire ack_done = ack_rcvd_i & ~ack_busy_i;
    wire ack_retry = ack_rcvd_i & ack_busy_i;

    assign mem_req_o = (state_reg == ST_FETCH) | (state_reg == ST_WB) | (state_reg == ST_POLL);
    assign mem_we_o = (state_reg == ST_WB);
    assign mem_wdata_o = {ctx_word, stamp_reg};
    assign mem_addr_o = (state_reg == ST_FETCH) ? unit_addr(cmdptr_reg, beat_unit, beat_word) :
                        (state_reg == ST_WB) ? unit_addr(cmdptr_reg, last_unit_reg, WRD_STATUS) :
                        unit_addr(cmdptr_reg, last_unit_reg, WRD_BRANCH);

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: begin
                if (run && cmd_z != Z_END) begin
                    state_next = ST_CHECK;
                end
            end
            ST_CHECK: begin
                if (!run || cmd_z == Z_END) begin
                    state_next = ST_IDLE;
                end else if (z_legal) begin
                    state_next = ST_FETCH;
                end else begin
                    state_next = ST_IDLE;
                end
            end
            ST_FETCH: begin
                if (fetch_last_beat) begin
                    state_next = ST_SEND;
                end
            end
            ST_SEND: state_next = ST_WAIT_LINK;
            ST_WAIT_LINK: begin
                if (link_done_i) begin
                    state_next = ST_WAIT_ACK;
                end
            end
            ST_WAIT_ACK: begin
                if (ack_retry) begin
                    state_next = ST_SEND;
                end else if (ack_done || ack_timeout_i) begin
                    state_next = ST_WB;
                end
            end
            ST_WB: begin
                if (mem_ack_i) begin
                    state_next = (branch_z == Z_END) ? ST_END : ST_CHECK;
                end
            end
            ST_END: begin
                if (!run) begin
                    state_next = ST_IDLE;
                end else if (wake_wr) begin
                    state_next = ST_POLL;
                end
            end
            ST_POLL: begin
                if (mem_ack_i) begin
                    state_next = (mem_rdata_i[3:0] == Z_END) ? ST_END : ST_CHECK;
                end
            end
            default: state_next = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_reg <= ST_IDLE;
            tx_start_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            tx_start_reg <= (state_reg == ST_SEND);
        end
    end

    // software control; wake is a command strobe and never stored
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ctrl_reg <= CTRL_RESET;
        end else if (apb_wr && hit_ctrl) begin
            ctrl_reg <= pwdata_i[15:0] & ~(16'h0001 << CTRL_WAKE_BIT);
        end
    end

    // pointer: software loads it while idle, hardware follows the chain
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cmdptr_reg <= CMDPTR_RESET;
        end else if (state_reg == ST_WB && mem_ack_i && branch_z != Z_END) begin
            cmdptr_reg <= branch_reg;
        end else if (state_reg == ST_POLL && mem_ack_i && mem_rdata_i[3:0] != Z_END) begin
            cmdptr_reg <= mem_rdata_i;
        end else if (apb_wr && hit_cmdptr && !busy) begin
            cmdptr_reg <= pwdata_i;
        end
    end

    // block walk: finds the final output descriptor while fetching
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            widx_reg <= MEM_AW'(0);
            walk_unit_reg <= 4'h0;
            last_unit_reg <= 4'h0;
            found_last_reg <= 1'b0;
            ping_flag_reg <= 1'b0;
            branch_reg <= 32'h0000_0000;
        end else if (state_reg == ST_CHECK) begin
            widx_reg <= MEM_AW'(0);
            walk_unit_reg <= 4'h0;
            found_last_reg <= 1'b0;
            ping_flag_reg <= 1'b0;
            branch_reg <= 32'h0000_0000;
        end else if (fetch_beat) begin
            widx_reg <= widx_reg + MEM_AW'(1);
            if (hdr_beat && !found_last_reg) begin
                walk_unit_reg <= walk_unit_reg + (hdr_is_imm ? IMM_UNITS : 4'h1);
                if (hdr_is_last) begin
                    found_last_reg <= 1'b1;
                    last_unit_reg <= beat_unit;
                    ping_flag_reg <= mem_rdata_i[PING_BIT];
                end
            end
            if (br_beat) begin
                branch_reg <= mem_rdata_i;
            end
        end
    end

    // completion event code and stamp capture
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            evt_reg <= {EVT_W{1'b0}};
            stamp_reg <= 16'h0000;
        end else if (state_reg == ST_CHECK && !z_legal && cmd_z != Z_END) begin
            evt_reg <= EVT_BAD_Z_CODE;
        end else if (state_reg == ST_WAIT_ACK && (ack_done || ack_timeout_i)) begin
            evt_reg <= ack_timeout_i ? EVT_TIMEOUT_CODE : ack_code_i;
            if (ping_flag_reg) begin
                stamp_reg <= ping_cnt_reg;
            end else begin
                stamp_reg <= stamp_now;
            end
        end
    end

    // ping time base: two flops, then edge detect on the settled copies
    wire ping_tick = tick_sync_reg[1] ^ tick_sync_reg[2];
    wire ping_stop = rx_indication_i | subaction_gap_i;
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tick_sync_reg <= 3'b000;
        end else begin
            tick_sync_reg <= {tick_sync_reg[1:0], ping_tick_i};
        end
    end

    // restart after every sent packet so a retry remeasures
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ping_cnt_reg <= 16'h0000;
            ping_run_reg <= 1'b0;
            ping_last_reg <= 16'h0000;
        end else if (link_done_i) begin
            ping_cnt_reg <= 16'h0000;
            ping_run_reg <= 1'b1;
        end else if (ping_run_reg && ping_stop) begin
            ping_run_reg <= 1'b0;
            ping_last_reg <= ping_cnt_reg;
        end else if (ping_run_reg && ping_tick && ping_cnt_reg != 16'hFFFF) begin
            ping_cnt_reg <= ping_cnt_reg + 16'h0001;
        end
    end

    atd_desc_mem #(
        .DEPTH(MAX_UNITS * WORDS_PER_UNIT),
        .AW(MEM_AW)
    ) u_mem (
        .clk_i(clk_i),
        .we_i(fetch_beat),
        .waddr_i(widx_reg),
        .wdata_i(mem_rdata_i),
        .raddr_i(tx_raddr_i),
        .rdata_o(tx_rdata_o)
    );
endmodule

// ===== test/atd_engine_monitor.sv
// Purpose: port checks of the transmit descriptor engine
// Assumes: one clock, async active-low reset
// Notes: bound to every atd_engine instance
`timescale 1ns/1ps
module atd_engine_monitor (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic mem_req_o,
    input wire logic mem_we_o,
    input wire logic [31:0] mem_addr_o,
    input wire logic [31:0] mem_wdata_o,
    input wire logic mem_ack_i,
    input wire logic tx_start_o,
    input wire logic ack_rcvd_i,
    input wire logic ack_busy_i,
    input wire logic ack_timeout_i
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    property p_prefetch; tx_start_o |-> !mem_req_o && $past(!mem_req_o); endproperty
    a_prefetch: assert property (p_prefetch)
        else $error("fetch busy at transmit start");
    property p_quiet; tx_start_o |=> !mem_req_o && !tx_start_o; endproperty
    a_quiet: assert property (p_quiet)
        else $error("fetch during transfer");
    property p_hold;
        mem_req_o && !mem_ack_i |=> mem_req_o && $stable(mem_addr_o) && $stable(mem_wdata_o);
    endproperty
    a_hold: assert property (p_hold)
        else $error("memory request changed before ack");
    property p_one_write; mem_req_o && mem_we_o && mem_ack_i |=> !(mem_req_o && mem_we_o); endproperty
    a_one_write: assert property (p_one_write)
        else $error("second completion write");
    property p_status; mem_req_o && mem_we_o |-> mem_wdata_o[31] && mem_addr_o[3:0] == 4'hC; endproperty
    a_status: assert property (p_status)
        else $error("status write malformed");
    property p_ack_wb; ack_rcvd_i && !ack_busy_i |=> mem_req_o && mem_we_o; endproperty
    a_ack_wb: assert property (p_ack_wb)
        else $error("no write after ack");
    property p_to_wb; ack_timeout_i |=> mem_req_o && mem_we_o; endproperty
    a_to_wb: assert property (p_to_wb)
        else $error("no write after ack timeout");
    property p_retry; ack_rcvd_i && ack_busy_i |-> ##2 tx_start_o; endproperty
    a_retry: assert property (p_retry)
        else $error("no retry after busy ack");
    property p_contig;
        mem_req_o && !mem_we_o && mem_ack_i ##1 mem_req_o && !mem_we_o
            |-> mem_addr_o == $past(mem_addr_o) + 32'h0000_0004;
    endproperty
    a_contig: assert property (p_contig)
        else $error("block fetch not contiguous");
endmodule
bind atd_engine atd_engine_monitor atd_engine_monitor_inst (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .mem_req_o(mem_req_o), .mem_we_o(mem_we_o), .mem_addr_o(mem_addr_o),
    .mem_wdata_o(mem_wdata_o), .mem_ack_i(mem_ack_i), .tx_start_o(tx_start_o),
    .ack_rcvd_i(ack_rcvd_i), .ack_busy_i(ack_busy_i), .ack_timeout_i(ack_timeout_i));

// ===== test/atd_host_mem_model.sv
// Purpose: host memory holding descriptor programs
// Assumes: one word per ack, latency set by lat_i
// Notes: read data toggles when not acked, so stale data never looks valid
`timescale 1ns/1ps
module atd_host_mem_model (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic mem_req_i,
    input wire logic mem_we_i,
    input wire logic [31:0] mem_addr_i,
    input wire logic [31:0] mem_wdata_i,
    input wire logic [3:0] lat_i,
    output logic mem_ack_o,
    output logic [31:0] mem_rdata_o
);
    logic [31:0] mem [0:255];
    logic [3:0] wait_cnt;
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            mem_ack_o <= 1'b0;
            wait_cnt <= 4'h0;
            mem_rdata_o <= 32'h5A5A_5A5A;
        end else if (!mem_ack_o && mem_req_i && wait_cnt >= lat_i) begin
            mem_ack_o <= 1'b1;
            wait_cnt <= 4'h0;
            if (mem_we_i)
                mem[mem_addr_i[9:2]] <= mem_wdata_i;
            else
                mem_rdata_o <= mem[mem_addr_i[9:2]];
        end else begin
            mem_ack_o <= 1'b0;
            wait_cnt <= (mem_req_i && !mem_ack_o) ? wait_cnt + 4'h1 : 4'h0;
            mem_rdata_o <= ~mem_rdata_o;
        end
    end
endmodule

// ===== test/test_async_tx_descriptor_handling.sv
// Purpose: directed tests of descriptor fetch, writeback and ping timing
// Assumes: APB zero wait, 20 MHz clock
// Notes: link events are pulsed by the bench in place of the PHY
`timescale 1ns/1ps
module test_async_tx_descriptor_handling;
    import atd_pkg::*;
    logic clk_i = 1'b0, rst_n_i = 1'b0, psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
    logic [7:0] paddr_i = 8'h00;
    logic [31:0] pwdata_i = 32'h0000_0000, prdata_o, mem_addr_o, mem_wdata_o, mem_rdata_i, q;
    logic pready_o, pslverr_o, mem_req_o, mem_we_o, mem_ack_i, tx_start_o, active_o, e;
    logic link_done_i = 1'b0, ack_rcvd_i = 1'b0, ack_busy_i = 1'b0, ack_timeout_i = 1'b0;
    logic rx_indication_i = 1'b0, subaction_gap_i = 1'b0, ping_tick_i = 1'b0;
    logic [4:0] ack_code_i = 5'h11;
    logic [2:0] seconds_low_bits_i = 3'h0;
    logic [12:0] cycle_number_i = 13'h0000;
    logic [3:0] lat = 4'h0;
    logic [4:0] tx_raddr = 5'h00, tx_base_o;
    logic [31:0] tx_rdata_o;
    int n_mismatch = 0, comparisons = 0, rd_cnt = 0;
    atd_engine #(.MAX_UNITS(8), .MEM_AW(5)) atd_engine_inst (.clk_i, .rst_n_i, .psel_i,
        .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o,
        .mem_req_o, .mem_we_o, .mem_addr_o, .mem_wdata_o, .mem_ack_i, .mem_rdata_i,
        .tx_raddr_i(tx_raddr), .tx_rdata_o, .tx_base_o, .tx_start_o, .link_done_i,
        .ack_rcvd_i, .ack_busy_i, .ack_code_i, .ack_timeout_i, .rx_indication_i,
        .subaction_gap_i, .seconds_low_bits_i, .cycle_number_i, .ping_tick_i, .active_o);
    atd_host_mem_model atd_host_mem_model_inst (.clk_i, .rst_n_i, .mem_req_i(mem_req_o),
        .mem_we_i(mem_we_o), .mem_addr_i(mem_addr_o), .mem_wdata_i(mem_wdata_o),
        .lat_i(lat), .mem_ack_o(mem_ack_i), .mem_rdata_o(mem_rdata_i));
    initial begin
        forever #25 clk_i = ~clk_i;
    end
    always @(posedge clk_i) if (mem_ack_i === 1'b1 && mem_we_o === 1'b0) rd_cnt <= rd_cnt + 1;
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        psel_i <= 1'b1;
        pwrite_i <= wr;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge clk_i);
        penable_i <= 1'b1;
        do @(posedge clk_i); while (pready_o !== 1'b1);
        q = prdata_o;
        e = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask
    task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        chk(what, q, exp);
    endtask
    task automatic wm(input int a, input logic [31:0] d);
        atd_host_mem_model_inst.mem[a / 4] = d;
    endtask
    task automatic tick();
        ping_tick_i <= ~ping_tick_i;
        repeat (4) @(posedge clk_i);
    endtask
    // how: 0 good ack, 1 busy ack, 2 ack timeout
    // ix/exp_w: one prefetched word, read back before the link reports the packet sent
    task automatic attempt(input int nt, input logic [1:0] how, input int exp_rd,
                           input logic [4:0] ix, input logic [31:0] exp_w);
        for (int i = 0; i < 400 && tx_start_o !== 1'b1; i++) @(posedge clk_i);
        chk("transmit start", {31'h0, tx_start_o}, 32'h0000_0001);
        chk("reads before transmit", rd_cnt, exp_rd);
        tx_raddr <= ix;
        repeat (2) @(posedge clk_i);
        chk("prefetched word", tx_rdata_o, exp_w);
        chk("block base", {27'h000_0000, tx_base_o}, 32'h0000_0000);
        link_done_i <= 1'b1;
        @(posedge clk_i);
        link_done_i <= 1'b0;
        repeat (nt) tick();
        subaction_gap_i <= (how == 2'd1);
        rx_indication_i <= (how != 2'd1);
        @(posedge clk_i);
        subaction_gap_i <= 1'b0;
        rx_indication_i <= 1'b0;
        // ticks after the stop event must not be counted
        repeat (2) tick();
        ack_rcvd_i <= (how != 2'd2);
        ack_busy_i <= (how == 2'd1);
        ack_timeout_i <= (how == 2'd2);
        @(posedge clk_i);
        ack_rcvd_i <= 1'b0;
        ack_busy_i <= 1'b0;
        ack_timeout_i <= 1'b0;
    endtask
    task automatic wb_chk(input logic [31:0] a, input logic [31:0] exp);
        for (int i = 0; i < 400 && !(mem_ack_i === 1'b1 && mem_we_o === 1'b1); i++)
            @(posedge clk_i);
        chk("writeback address", mem_addr_o, a);
        chk("writeback word", atd_host_mem_model_inst.mem[a[9:2]], exp);
    endtask
    initial begin
        repeat (20000) @(posedge clk_i);
        n_mismatch++;
        final_report();
    end
    initial begin
        for (int k = 0; k < 256; k++) wm(k * 4, 32'h0000_0000);
        wm(32'h100, 32'h1200_0000);
        wm(32'h200, 32'h1280_0000);
        wm(32'h208, 32'h0000_0303);
        wm(32'h300, 32'h0200_0000);
        wm(32'h308, 32'h0000_0502);
        wm(32'h320, 32'h1000_0000);
        repeat (16) @(posedge clk_i);
        rst_n_i <= 1'b1;
        rd_chk("ctrl reset", OFS_CTRL, {16'h0000, CTRL_RESET});
        rd_chk("cmdptr reset", OFS_CMDPTR, CMDPTR_RESET);
        rd_chk("unmapped read", 8'h10, 32'h0000_0000);
        chk("unmapped error", {31'h0, e}, 32'h0000_0001);
        $display("test registers done");
        apb(1'b1, OFS_CMDPTR, 32'h0000_0102);
        rd_chk("cmdptr", OFS_CMDPTR, 32'h0000_0102);
        seconds_low_bits_i <= 3'h5;
        cycle_number_i <= 13'd7999;
        apb(1'b1, OFS_CTRL, 32'h0000_8000);
        attempt(0, 2'd0, 8, 5'h00, 32'h1200_0000);
        wb_chk(32'h0000_010C, 32'h8411_BF3F);
        $display("test single block done");
        repeat (10) @(posedge clk_i);
        wm(32'h108, 32'h0000_0202);
        lat <= 4'h3;
        apb(1'b1, OFS_CTRL, 32'h0000_9000);
        attempt(3, 2'd1, 17, 5'h02, 32'h0000_0303);
        attempt(5, 2'd0, 17, 5'h02, 32'h0000_0303);
        wb_chk(32'h0000_020C, 32'h8411_0005);
        rd_chk("ping count", OFS_PING, 32'h0000_0005);
        seconds_low_bits_i <= 3'h2;
        cycle_number_i <= 13'h0000;
        attempt(0, 2'd2, 29, 5'h08, 32'h1000_0000);
        wb_chk(32'h0000_032C, 32'h840A_4000);
        repeat (20) @(posedge clk_i);
        chk("reads after end", rd_cnt, 29);
        chk("active at end", {31'h0000_0000, active_o}, 32'h0000_0001);
        rd_chk("ctrl at end", OFS_CTRL, 32'h0000_840A);
        rd_chk("status at end", OFS_STATUS, {12'h000, ST_END, 16'h4000});
        $display("test append ping timeout done");
        apb(1'b1, OFS_CTRL, 32'h0000_0000);
        for (int z = 0; z < 10; z += 9) begin
            apb(1'b1, OFS_CMDPTR, 32'h0000_0400 | z);
            apb(1'b1, OFS_CTRL, 32'h0000_8000);
            repeat (20) @(posedge clk_i);
            chk("reads at end count", rd_cnt, 29);
            if (z == 0)
                chk("idle at zero count", {31'h0000_0000, active_o}, 32'h0000_0000);
            apb(1'b0, OFS_CTRL, 32'h0000_0000);
            if (z == 9)
                chk("reserved count event", {27'h0, q[4:0]}, {27'h0, EVT_BAD_Z_CODE});
            apb(1'b1, OFS_CTRL, 32'h0000_0000);
        end
        $display("test block count ends done");
        final_report();
    end
endmodule
